// file: hdl/hmb_chk.sv
// Running check accumulator: table-driven CRC-16 and 8-bit LRC side by side.
// Assumes: clr loads the seeds; a byte offered with clr starts from the seeds.
`timescale 1ns/1ns
`include "hmb_regs.svh"
module hmb_chk (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   hmb_chk_if.acc    chk
);
   logic [15:0] crc_ff;
   logic [7:0]  lrc_ff;
   logic [15:0] crc_base;
   logic [7:0]  lrc_base;
   logic [15:0] crc_x;

   // Table entry for one index; a loop keeps the 256 entries out of the source
   function automatic logic [15:0] crc_tbl(input logic [7:0] idx);
      logic [15:0] c;
      c = {8'h00, idx};
      for (int k = 0; k < int'(`HMB_BYTE_BITS); k++) begin
         c = c[0] ? ((c >> 1) ^ `HMB_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc_tbl

   // Seeds apply to the byte that arrives with clr
   assign crc_base = chk.clr ? `HMB_CRC_SEED : crc_ff;
   assign lrc_base = chk.clr ? `HMB_LRC_SEED : lrc_ff;
   assign crc_x    = crc_base ^ {8'h00, chk.din};
   assign chk.crc  = crc_ff;
   assign chk.lrc  = lrc_ff;

   // CRC: low byte indexes the table, high byte folds in, result seeds next byte
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         crc_ff <= `HMB_CRC_SEED;
      end else if (chk.en) begin
         crc_ff <= {8'h00, crc_x[15:8]} ^ crc_tbl(crc_x[7:0]);
      end else if (chk.clr) begin
         crc_ff <= `HMB_CRC_SEED;
      end
   end

   // LRC: plain byte sum, carries beyond eight bits fall away
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lrc_ff <= `HMB_LRC_SEED;
      end else if (chk.en) begin
         lrc_ff <= lrc_base + chk.din;
      end else if (chk.clr) begin
         lrc_ff <= `HMB_LRC_SEED;
      end
   end
endmodule : hmb_chk

// file: hdl/hmb_chk_if.sv
// Carrier between the frame engine and one check accumulator.
// Assumes: one clock; clr and en are single-cycle strobes from the engine.
`timescale 1ns/1ns
interface hmb_chk_if;
   logic        clr;
   logic        en;
   logic [7:0]  din;
   logic [15:0] crc;
   logic [7:0]  lrc;
   modport user (output clr, output en, output din, input crc, input lrc);
   modport acc  (input clr, input en, input din, output crc, output lrc);
endinterface : hmb_chk_if

// file: hdl/hmb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes: one clock, asynchronous active-low reset.
`timescale 1ns/1ns
module hmb_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   // Fill side
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   // Drain side
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;

   // Full and empty come straight from the occupancy count
   assign o_in_ready  = (cnt_ff != D[AW:0]);
   assign o_out_valid = (cnt_ff != '0);
   assign o_out_data  = mem_ff[rd_ff];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // Storage needs no reset; it is never read while empty
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= i_in_data;
      end
   end

   // Pointers wrap at the power-of-two depth
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop)  rd_ff <= rd_ff + 1'b1;
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : hmb_fifo

// file: hdl/hmb_host.sv
// Modbus host: builds request frames with checks and verifies answers.
// Assumes: a UART on the same clock takes O_TX bytes/characters and delivers
// received ones on I_RX; in RTU mode it also flags the silent gap on I_RX_END.
//
// What this block does
// - Register reference number is the register number with leading 4.
// - Relay reference number is the relay number without its letter.
// - Register message address is reference number minus 40001.
// - Relay message address is reference number minus one.
// - ASCII frames carry LRC; RTU frames carry CRC-16.
// - LRC is two's complement of byte sum, address to last data.
// - ASCII sends each byte as two hex characters; checks use bytes.
// - CRC covers eight data bits per byte, sixteen-bit remainder.
// - CRC starts at all ones each frame; address byte XORs in first.
// - Low byte of XOR result indexes the A001h table.
// - High byte of XOR result XORs with the table entry.
// - Result seeds the next byte, through the last data byte.
// - CRC appended low byte first, then high byte.
`timescale 1ns/1ns
`include "hmb_regs.svh"
module hmb_host (
   // Clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST_B,
   // Link mode
   input  wire logic        I_MODE_ASCII,
   // Request command
   input  wire logic        I_CMD_VALID,
   output logic             O_CMD_READY,
   input  wire logic        I_CMD_RELAY,
   input  wire logic [7:0]  I_CMD_SLAVE,
   input  wire logic [7:0]  I_CMD_FUNC,
   input  wire logic [15:0] I_CMD_NUM,
   input  wire logic [15:0] I_CMD_DATA,
   // Transmit stream to the UART
   output logic             O_TX_VALID,
   input  wire logic        I_TX_READY,
   output logic [7:0]       O_TX_DATA,
   // Receive stream from the UART
   input  wire logic        I_RX_VALID,
   input  wire logic [7:0]  I_RX_DATA,
   input  wire logic        I_RX_END,
   // Status
   output logic [15:0]      O_MSG_ADDR,
   output logic             O_RX_OK,
   output logic             O_RX_ERR
);
   // Transmit engine state
   hmb_pkg::hmb_tx_st_t tx_st_ff;
   logic [7:0]          frame_ff [6];
   logic [2:0]          idx_ff;
   logic                nib_ff;
   logic                ascii_ff;
   logic [15:0]         addr_ff;
   // Receive checker state
   hmb_pkg::hmb_rx_st_t rx_st_ff;
   logic [3:0]          rx_hi_ff;
   logic                rx_half_ff;
   logic [7:0]          rx_cnt_ff;
   logic                rx_bad_ff;
   logic                rx_pnd_ff;
   logic                rx_asc_ff;
   logic                ok_ff;
   logic                err_ff;
   // Combinational terms
   logic                take;
   logic [15:0]         ref_num;
   logic [15:0]         nxt_addr;
   logic                push;
   logic                fifo_ready;
   logic [7:0]          tx_char;
   logic [7:0]          tx_byte;
   logic [7:0]          lrc_out;
   logic                step;
   logic                byte_done;
   logic [4:0]          rx_nib;
   logic                rx_hex;

   hmb_chk_if tx_chk ();
   hmb_chk_if rx_chk ();

   // One accumulator per direction, so a reply may arrive while a request drains
   hmb_chk u_tx_chk (
      .i_clk   (I_CORE_CLK),
      .i_rst_b (I_RST_B),
      .chk     (tx_chk.acc)
   );
   hmb_chk u_rx_chk (
      .i_clk   (I_CORE_CLK),
      .i_rst_b (I_RST_B),
      .chk     (rx_chk.acc)
   );

   // Characters queue here; a stalled UART stalls the engine through fifo_ready
   hmb_fifo #(
      .W (8),
      .D (`HMB_FIFO_DEPTH)
   ) u_tx_fifo (
      .i_clk       (I_CORE_CLK),
      .i_rst_b     (I_RST_B),
      .i_in_valid  (push),
      .o_in_ready  (fifo_ready),
      .i_in_data   (tx_char),
      .o_out_valid (O_TX_VALID),
      .i_out_ready (I_TX_READY),
      .o_out_data  (O_TX_DATA)
   );

   // Reference number first, then the zero-based message address
   always_comb begin
      if (I_CMD_RELAY) begin
         ref_num  = I_CMD_NUM;
         nxt_addr = ref_num - `HMB_RLY_OFS;
      end else begin
         ref_num  = I_CMD_NUM + `HMB_REG_REF_BASE;
         nxt_addr = ref_num - `HMB_REG_OFS;
      end
   end

   assign O_CMD_READY = (tx_st_ff == hmb_pkg::HMB_TX_IDLE);
   assign take        = I_CMD_VALID & O_CMD_READY;
   assign push        = (tx_st_ff != hmb_pkg::HMB_TX_IDLE);
   assign step        = push & fifo_ready;
   assign O_MSG_ADDR  = addr_ff;
   assign O_RX_OK     = ok_ff;
   assign O_RX_ERR    = err_ff;
   assign lrc_out     = ~tx_chk.lrc + 8'h01;

   // Byte in flight: frame byte, LRC, or CRC low then high
   always_comb begin
      if (tx_st_ff == hmb_pkg::HMB_TX_DATA) begin
         tx_byte = frame_ff[idx_ff];
      end else if (ascii_ff) begin
         tx_byte = lrc_out;
      end else if (idx_ff == 3'h0) begin
         tx_byte = tx_chk.crc[7:0];
      end else begin
         tx_byte = tx_chk.crc[15:8];
      end
   end

   // Character offered to the FIFO in each state
   always_comb begin
      case (tx_st_ff)
         hmb_pkg::HMB_TX_COLON: tx_char = `HMB_CH_COLON;
         hmb_pkg::HMB_TX_CR:    tx_char = `HMB_CH_CR;
         hmb_pkg::HMB_TX_LF:    tx_char = `HMB_CH_LF;
         hmb_pkg::HMB_TX_DATA,
         hmb_pkg::HMB_TX_CHK: begin
            if (ascii_ff) begin
               tx_char = hmb_pkg::hmb_hex_chr(nib_ff ? tx_byte[3:0] : tx_byte[7:4]);
            end else begin
               tx_char = tx_byte;
            end
         end
         default: tx_char = 8'h00;
      endcase
   end

   // A data byte counts once it is fully queued; binary value, not characters
   assign byte_done  = step & (tx_st_ff == hmb_pkg::HMB_TX_DATA) & (~ascii_ff | nib_ff);
   assign tx_chk.clr = take;
   assign tx_chk.en  = byte_done;
   assign tx_chk.din = frame_ff[idx_ff];

   // Frame contents latched at the command
   always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         for (int k = 0; k < 6; k++) begin
            frame_ff[k] <= 8'h00;
         end
         addr_ff  <= 16'h0000;
         ascii_ff <= 1'b0;
      end else if (take) begin
         frame_ff[0] <= I_CMD_SLAVE;
         frame_ff[1] <= I_CMD_FUNC;
         frame_ff[2] <= nxt_addr[15:8];
         frame_ff[3] <= nxt_addr[7:0];
         frame_ff[4] <= I_CMD_DATA[15:8];
         frame_ff[5] <= I_CMD_DATA[7:0];
         addr_ff     <= nxt_addr;
         ascii_ff    <= I_MODE_ASCII;
      end
   end

   // Transmit sequencer; leaves idle on take, then advances only when the FIFO takes the character
   always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         tx_st_ff <= hmb_pkg::HMB_TX_IDLE;
         idx_ff   <= 3'h0;
         nib_ff   <= 1'b0;
      end else begin
         case (tx_st_ff)
            hmb_pkg::HMB_TX_IDLE: begin
               idx_ff <= 3'h0;
               nib_ff <= 1'b0;
               if (take) begin
                  tx_st_ff <= I_MODE_ASCII ? hmb_pkg::HMB_TX_COLON : hmb_pkg::HMB_TX_DATA;
               end
            end
            hmb_pkg::HMB_TX_COLON: begin
               if (step) tx_st_ff <= hmb_pkg::HMB_TX_DATA;
            end
            hmb_pkg::HMB_TX_DATA: begin
               if (step) begin
                  if (ascii_ff && !nib_ff) begin
                     nib_ff <= 1'b1;
                  end else begin
                     nib_ff <= 1'b0;
                     if (idx_ff == `HMB_LAST_BYTE) begin
                        idx_ff   <= 3'h0;
                        tx_st_ff <= hmb_pkg::HMB_TX_CHK;
                     end else begin
                        idx_ff <= idx_ff + 3'h1;
                     end
                  end
               end
            end
            hmb_pkg::HMB_TX_CHK: begin
               if (step) begin
                  if (ascii_ff) begin
                     nib_ff <= ~nib_ff;
                     if (nib_ff) tx_st_ff <= hmb_pkg::HMB_TX_CR;
                  end else if (idx_ff == 3'h0) begin
                     idx_ff <= 3'h1;
                  end else begin
                     idx_ff   <= 3'h0;
                     tx_st_ff <= hmb_pkg::HMB_TX_IDLE;
                  end
               end
            end
            hmb_pkg::HMB_TX_CR: begin
               if (step) tx_st_ff <= hmb_pkg::HMB_TX_LF;
            end
            hmb_pkg::HMB_TX_LF: begin
               if (step) tx_st_ff <= hmb_pkg::HMB_TX_IDLE;
            end
            default: tx_st_ff <= hmb_pkg::HMB_TX_IDLE;
         endcase
      end
   end

   // Receive decode: colon restarts in ASCII; first byte after idle in RTU
   assign rx_nib = hmb_pkg::hmb_chr_nib(I_RX_DATA);
   assign rx_hex = rx_nib[4];

   always_comb begin
      rx_chk.clr = 1'b0;
      rx_chk.en  = 1'b0;
      rx_chk.din = I_RX_DATA;
      if (I_RX_VALID) begin
         if (I_MODE_ASCII) begin
            rx_chk.din = {rx_hi_ff, rx_nib[3:0]};
            rx_chk.clr = (I_RX_DATA == `HMB_CH_COLON);
            rx_chk.en  = (rx_st_ff == hmb_pkg::HMB_RX_BODY) && rx_hex && rx_half_ff;
         end else begin
            rx_chk.clr = (rx_st_ff == hmb_pkg::HMB_RX_IDLE);
            rx_chk.en  = 1'b1;
         end
      end
   end

   // Receive framing; a frame end is judged one cycle later so the last byte settles
   always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rx_st_ff   <= hmb_pkg::HMB_RX_IDLE;
         rx_hi_ff   <= 4'h0;
         rx_half_ff <= 1'b0;
         rx_cnt_ff  <= 8'h00;
         rx_bad_ff  <= 1'b0;
         rx_pnd_ff  <= 1'b0;
         rx_asc_ff  <= 1'b0;
      end else begin
         rx_pnd_ff <= 1'b0;
         if (I_MODE_ASCII) begin
            if (I_RX_VALID) begin
               if (I_RX_DATA == `HMB_CH_COLON) begin
                  rx_st_ff   <= hmb_pkg::HMB_RX_BODY;
                  rx_half_ff <= 1'b0;
                  rx_cnt_ff  <= 8'h00;
                  rx_bad_ff  <= 1'b0;
               end else if (rx_st_ff == hmb_pkg::HMB_RX_BODY) begin
                  if (I_RX_DATA == `HMB_CH_LF) begin
                     rx_st_ff  <= hmb_pkg::HMB_RX_IDLE;
                     rx_pnd_ff <= 1'b1;
                     rx_asc_ff <= 1'b1;
                  end else if (I_RX_DATA != `HMB_CH_CR) begin
                     if (!rx_hex) begin
                        rx_bad_ff <= 1'b1;
                     end
                     rx_hi_ff   <= rx_nib[3:0];
                     rx_half_ff <= ~rx_half_ff;
                     if (rx_half_ff && rx_cnt_ff != 8'hff) rx_cnt_ff <= rx_cnt_ff + 8'h01;
                  end
               end
            end
         end else begin
            if (I_RX_VALID) begin
               rx_st_ff <= hmb_pkg::HMB_RX_BODY;
               if (rx_st_ff == hmb_pkg::HMB_RX_IDLE) begin
                  rx_cnt_ff <= 8'h01;
               end else if (rx_cnt_ff != 8'hff) begin
                  rx_cnt_ff <= rx_cnt_ff + 8'h01;
               end
            end
            if (I_RX_END && (rx_st_ff == hmb_pkg::HMB_RX_BODY || I_RX_VALID)) begin
               rx_st_ff  <= hmb_pkg::HMB_RX_IDLE;
               rx_pnd_ff <= 1'b1;
               rx_asc_ff <= 1'b0;
            end
         end
      end
   end

   // Verdict: a good frame leaves a zero remainder over data plus its check bytes
   always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ok_ff  <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ok_ff  <= 1'b0;
         err_ff <= 1'b0;
         if (rx_pnd_ff) begin
            if (rx_asc_ff) begin
               if (!rx_bad_ff && !rx_half_ff && rx_cnt_ff >= `HMB_ASC_MIN && rx_chk.lrc == `HMB_LRC_SEED) begin
                  ok_ff <= 1'b1;
               end else begin
                  err_ff <= 1'b1;
               end
            end else begin
               if (rx_cnt_ff >= `HMB_RTU_MIN && rx_chk.crc == `HMB_CRC_ZERO) begin
                  ok_ff <= 1'b1;
               end else begin
                  err_ff <= 1'b1;
               end
            end
         end
      end
   end
endmodule : hmb_host

// file: hdl/hmb_pkg.sv
// Types and character helpers shared by the Modbus host modules.
// Assumes: hmb_regs.svh is on the include path.
`include "hmb_regs.svh"
package hmb_pkg;
   typedef enum logic [5:0] {
      HMB_TX_IDLE  = 6'h01,
      HMB_TX_COLON = 6'h02,
      HMB_TX_DATA  = 6'h04,
      HMB_TX_CHK   = 6'h08,
      HMB_TX_CR    = 6'h10,
      HMB_TX_LF    = 6'h20
   } hmb_tx_st_t;
   typedef enum logic [1:0] {
      HMB_RX_IDLE = 2'h1,
      HMB_RX_BODY = 2'h2
   } hmb_rx_st_t;
   // Nibble to upper-case hex character
   function automatic logic [7:0] hmb_hex_chr(input logic [3:0] nib);
      return (nib < `HMB_NIB_TEN) ? (`HMB_CH_ZERO + {4'h0, nib}) : (`HMB_CH_ALPHA + {4'h0, nib});
   endfunction : hmb_hex_chr
   // Character to {valid, nibble}; lower case is not accepted
   function automatic logic [4:0] hmb_chr_nib(input logic [7:0] ch);
      logic [7:0] d;
      d = 8'h00;
      if (ch >= `HMB_CH_ZERO && ch <= `HMB_CH_NINE) begin
         d = ch - `HMB_CH_ZERO;
         return {1'b1, d[3:0]};
      end
      if (ch >= `HMB_CH_UA && ch <= `HMB_CH_UF) begin
         d = ch - `HMB_CH_ALPHA;
         return {1'b1, d[3:0]};
      end
      return 5'h00;
   endfunction : hmb_chr_nib
endpackage : hmb_pkg

// file: hdl/hmb_regs.svh
// Named constants for the Modbus host frame builder and checker.
// Assumes: included by bare name from the package, the check accumulator and the host; the FIFO and interface files do not include it.
`ifndef HMB_REGS_SVH
`define HMB_REGS_SVH
// Addressing offsets
`define HMB_REG_REF_BASE 16'h9c40
`define HMB_REG_OFS      16'h9c41
`define HMB_RLY_OFS      16'h0001
// Check arithmetic
`define HMB_CRC_SEED     16'hffff
`define HMB_CRC_POLY     16'ha001
`define HMB_CRC_ZERO     16'h0000
`define HMB_LRC_SEED     8'h00
`define HMB_BYTE_BITS    4'h8
// Characters of the ASCII framing
`define HMB_CH_COLON     8'h3a
`define HMB_CH_CR        8'h0d
`define HMB_CH_LF        8'h0a
`define HMB_CH_ZERO      8'h30
`define HMB_CH_NINE      8'h39
`define HMB_CH_UA        8'h41
`define HMB_CH_UF        8'h46
`define HMB_CH_ALPHA     8'h37
`define HMB_NIB_TEN      4'ha
// Frame layout
`define HMB_LAST_BYTE    3'h5
`define HMB_RTU_MIN      8'h04
`define HMB_ASC_MIN      8'h02
`define HMB_FIFO_DEPTH   4
`endif

// file: tb/hmb_host_asserts.sv
// Port checker bound onto hmb_host.
// Assumes: one clock; verdicts come 2 cycles after the cause.
`timescale 1ns/1ns
module hmb_host_asserts (
   // Clock and reset
   input wire logic        I_CORE_CLK,
   input wire logic        I_RST_B,
   // Watched ports
   input wire logic        I_MODE_ASCII,
   input wire logic        I_CMD_VALID,
   input wire logic        O_CMD_READY,
   input wire logic [15:0] I_CMD_NUM,
   input wire logic        O_TX_VALID,
   input wire logic        I_TX_READY,
   input wire logic [7:0]  O_TX_DATA,
   input wire logic        I_RX_VALID,
   input wire logic [7:0]  I_RX_DATA,
   input wire logic        I_RX_END,
   input wire logic [15:0] O_MSG_ADDR,
   input wire logic        O_RX_OK,
   input wire logic        O_RX_ERR
);
   logic take, lf_in, seen_ff;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_B);
   // Take and LF decode
   assign take  = I_CMD_VALID && O_CMD_READY;
   assign lf_in = I_RX_VALID && I_MODE_ASCII && (I_RX_DATA == 8'h0a);
   // Bytes seen since the last gap
   always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) seen_ff <= 1'b0;
      else if (I_RX_END) seen_ff <= 1'b0;
      else if (I_RX_VALID) seen_ff <= 1'b1;
   end
   chk_ready_drop: assert property (take |=> !O_CMD_READY [*8])
      else $error("ready back mid-frame");
   chk_addr_calc: assert property (take |=> O_MSG_ADDR == $past(I_CMD_NUM) - 16'h0001)
      else $error("bad message address");
   chk_addr_hold: assert property (!take |=> $stable(O_MSG_ADDR))
      else $error("address moved");
   chk_tx_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
      else $error("tx data moved");
   chk_rx_excl: assert property (!(O_RX_OK && O_RX_ERR))
      else $error("ok and err together");
   chk_ok_pulse: assert property (O_RX_OK |=> !O_RX_OK)
      else $error("ok pulse too long");
   chk_rtu_verdict: assert property (!I_MODE_ASCII && I_RX_END && (seen_ff || I_RX_VALID)
      |-> ##2 (O_RX_OK || O_RX_ERR))
      else $error("no verdict after gap");
   chk_verdict_cause: assert property ((O_RX_OK || O_RX_ERR)
      |-> $past(lf_in, 2) || $past(I_RX_END && !I_MODE_ASCII, 2))
      else $error("verdict without end");
   cov_take: cover property (take);
   cov_ok: cover property (O_RX_OK);
   cov_err: cover property (O_RX_ERR);
endmodule : hmb_host_asserts

bind hmb_host hmb_host_asserts u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_MODE_ASCII(I_MODE_ASCII),
   .I_CMD_VALID(I_CMD_VALID), .O_CMD_READY(O_CMD_READY), .I_CMD_NUM(I_CMD_NUM), .O_TX_VALID(O_TX_VALID),
   .I_TX_READY(I_TX_READY), .O_TX_DATA(O_TX_DATA), .I_RX_VALID(I_RX_VALID), .I_RX_DATA(I_RX_DATA),
   .I_RX_END(I_RX_END), .O_MSG_ADDR(O_MSG_ADDR), .O_RX_OK(O_RX_OK), .O_RX_ERR(O_RX_ERR));

// file: tb/hmb_host_tb.sv
// Bench for the Modbus host block.
// Assumes: hmb_slave_model on the serial side; 10 MHz.
`timescale 1ns/1ns
module hmb_host_tb;
   typedef logic [7:0] hmb_bq_t[$];
   logic        core_clk, rst_b, mode_ascii, cmd_valid, cmd_ready, cmd_relay;
   logic [7:0]  cmd_slave, cmd_func, tx_data, rx_data;
   logic [15:0] cmd_num, cmd_data, msg_addr;
   logic        tx_valid, tx_ready, rx_valid, rx_end, rx_ok, rx_err, stall, ok_seen, err_seen;
   int          error_cnt, checks_done;
   hmb_host uut (.I_CORE_CLK(core_clk), .I_RST_B(rst_b), .I_MODE_ASCII(mode_ascii), .I_CMD_VALID(cmd_valid),
      .O_CMD_READY(cmd_ready), .I_CMD_RELAY(cmd_relay), .I_CMD_SLAVE(cmd_slave), .I_CMD_FUNC(cmd_func),
      .I_CMD_NUM(cmd_num), .I_CMD_DATA(cmd_data), .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready),
      .O_TX_DATA(tx_data), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .I_RX_END(rx_end),
      .O_MSG_ADDR(msg_addr), .O_RX_OK(rx_ok), .O_RX_ERR(rx_err));
   hmb_slave_model slv (.i_clk(core_clk), .i_stall(stall), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
      .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end));
   // 100 ns clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Verdicts pulse once; latch them
   always @(posedge core_clk) begin
      if (rx_ok === 1'b1) ok_seen = 1'b1;
      if (rx_err === 1'b1) err_seen = 1'b1;
   end
   task automatic check(input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task automatic timeout();
      error_cnt++;
      $display("unexpected at %0t: wait seen %h expected %h", $time, 1'b0, 1'b1);
      wrap_up();
   endtask : timeout
   // Holds the request until ready takes it
   task automatic cmd(input logic relay, input logic [7:0] sl, fn,
                      input logic [15:0] num, dat);
      int n;
      @(negedge core_clk);
      {cmd_valid, cmd_relay, cmd_slave, cmd_func, cmd_num, cmd_data} = {1'b1, relay, sl, fn, num, dat};
      n = 0;
      while (cmd_ready !== 1'b1) begin
         n++;
         if (n > 400) timeout();
         @(negedge core_clk);
      end
      @(negedge core_clk);
      cmd_valid = 1'b0;
   endtask : cmd
   // Text plus CR LF
   function automatic hmb_bq_t asc(input string s);
      hmb_bq_t q;
      for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
      q.push_back(8'h0d);
      q.push_back(8'h0a);
      return q;
   endfunction : asc
   task automatic expect_frame(input hmb_bq_t exp);
      int n;
      n = 0;
      while (slv.got.size() < exp.size()) begin
         n++;
         if (n > 400) timeout();
         @(negedge core_clk);
      end
      foreach (exp[i]) check({8'h00, slv.got[i]}, {8'h00, exp[i]});
      slv.got.delete();
   endtask : expect_frame
   // RTU request with the UART stalled
   task automatic t_rtu_stall();
      @(negedge core_clk);
      mode_ascii = 1'b0;
      stall = 1'b1;
      cmd(1'b0, 8'h0b, 8'h03, 16'd2018, 16'h0004);
      repeat (12) @(negedge core_clk);
      check({15'h0, cmd_ready}, 16'h0000);
      check(msg_addr, 16'h07e1);
      stall = 1'b0;
      expect_frame('{8'h0b, 8'h03, 8'h07, 8'he1, 8'h00, 8'h04, 8'h15, 8'he1});
      $display("test rtu_stall done");
   endtask : t_rtu_stall
   // ASCII register then relay request
   task automatic t_asc_pair();
      @(negedge core_clk);
      mode_ascii = 1'b1;
      cmd(1'b0, 8'h11, 8'h03, 16'd2018, 16'h0004);
      expect_frame(asc(":110307E1000400"));
      check(msg_addr, 16'h07e1);
      cmd(1'b1, 8'h01, 8'h01, 16'h0011, 16'h0008);
      expect_frame(asc(":010100100008E6"));
      check(msg_addr, 16'h0010);
      $display("test asc_pair done");
   endtask : t_asc_pair
   // Good and bad replies, both modes
   task automatic t_rx();
      int n;
      for (int i = 0; i < 4; i++) begin
         @(negedge core_clk);
         mode_ascii = i[1];
         {ok_seen, err_seen} = 2'b00;
         slv.send('{8'h0b, 8'h03, 8'h02, 8'h13, 8'h88}, i[1], i[0]);
         n = 0;
         while (!(ok_seen || err_seen)) begin
            n++;
            if (n > 10) timeout();
            @(negedge core_clk);
         end
         check({15'h0, ok_seen}, {15'h0, ~i[0]});
         check({15'h0, err_seen}, {15'h0, i[0]});
      end
      $display("test rx done");
   endtask : t_rx
   // Main sequence
   initial begin
      {rst_b, mode_ascii, cmd_valid, cmd_relay, stall, ok_seen, err_seen} = 7'h00;
      {cmd_slave, cmd_func, cmd_num, cmd_data} = 48'h0;
      error_cnt = 0;
      checks_done = 0;
      repeat (6) @(negedge core_clk);
      check({cmd_ready, tx_valid, 14'h0}, 16'h8000);
      check(msg_addr, 16'h0000);
      rst_b = 1'b1;
      t_rtu_stall();
      t_asc_pair();
      t_rx();
      wrap_up();
   end
endmodule : hmb_host_tb

// file: tb/hmb_slave_model.sv
// Slave model: collects request characters, sends framed replies.
// Assumes: one clock shared with the host.
`timescale 1ns/1ns
module hmb_slave_model (
   // Clock and stall
   input  wire logic       i_clk,
   input  wire logic       i_stall,
   // Request stream from the host
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready,
   // Reply stream to the host
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_end
);
   logic [7:0] got[$];
   initial begin
      {o_rx_valid, o_rx_data, o_rx_end} = 10'h000;
   end
   // Stall fills the host FIFO
   assign o_tx_ready = !i_stall;
   // Capture accepted characters
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
   end
   // Bit-serial CRC, same as the A001h table
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction : crc16
   function automatic logic [7:0] lrc(input logic [7:0] b[$]);
      logic [7:0] s;
      s = 8'h00;
      foreach (b[i]) s = s + b[i];
      return 8'h00 - s;
   endfunction : lrc
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction : hx
   // One character per two cycles; idle data is inverted
   task automatic put(input logic [7:0] ch);
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data  <= ch;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~ch;
   endtask : put
   // Reply frame; bad flips a bit after the check
   task automatic send(input logic [7:0] b[$], input logic ascii, bad);
      logic [7:0]  f[$];
      logic [15:0] c;
      f = b;
      c = crc16(b);
      if (ascii) f.push_back(lrc(b));
      else begin
         f.push_back(c[7:0]);
         f.push_back(c[15:8]);
      end
      if (bad) f[1] = f[1] ^ 8'h01;
      if (ascii) begin
         put(8'h3a);
         foreach (f[i]) begin
            put(hx(f[i][7:4]));
            put(hx(f[i][3:0]));
         end
         put(8'h0d);
         put(8'h0a);
      end else begin
         foreach (f[i]) put(f[i]);
         @(posedge i_clk);
         o_rx_end <= 1'b1;
         @(posedge i_clk);
         o_rx_end <= 1'b0;
      end
   endtask : send
endmodule : hmb_slave_model
